// >>> logic/spc_fault_hold.sv
/*
 * stretches the active-high fault indication to a minimum hold time.
 * assumes fault_i is a synchronous level.
 */
module spc_fault_hold #(
    parameter logic [19:0] HOLD = 20'h00001
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic fault_i,
    output logic      active_o
);
    logic [19:0] hold_reg;

    // restart the hold on every cycle the fault is still present
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hold_reg <= 20'h00000;
        end else if (fault_i) begin
            hold_reg <= HOLD;
        end else if (hold_reg != 20'h00000) begin
            hold_reg <= hold_reg - 20'h00001;
        end
    end

    assign active_o = fault_i || (hold_reg != 20'h00000);
endmodule : spc_fault_hold

// >>> logic/spc_params.svh
/*
 * timing counts and constants for the sink path control block.
 * assumes a 50 MHz clock on clk_i; times are given in microseconds.
 */
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

`define SPC_CLK_MHZ           50
`define SPC_SETTLE_TIME_US    1000
`define SPC_SETTLE_CYCLES     (`SPC_SETTLE_TIME_US * `SPC_CLK_MHZ)
`define SPC_HOLD_TIME_US      10000
`define SPC_HOLD_CYCLES       (`SPC_HOLD_TIME_US * `SPC_CLK_MHZ)
`define SPC_CNT_W             20

`endif

// >>> logic/spc_pkg.sv
/*
 * types shared by the sink path control files.
 * assumes the params header is included where counts are needed.
 */
package spc_pkg;
    typedef enum logic [1:0] {
        SPC_DISABLED,
        SPC_SINK_ACTIVE,
        SPC_SINK_FAULT
    } spc_state_t;
endpackage : spc_pkg

// >>> logic/spc_sink_ctrl.sv
/*
 * sink path control: state machine, supply switchover and fault pin.
 * holds the fsm, the path and protection outputs, the aux feed select.
 * assumes all detector inputs are synchronous levels from analog comparators.
 * assumes the fault pin has an external pull-up; its drive value is low
 * once out of reset (reset loads high) and only the output enable moves it.
 */
`include "spc_params.svh"

// What this block does
// RULE1: path off until supply settled and bus ok
// RULE2: system supply present feeds aux output
// RULE3: no supply: select bus regulator for aux
// RULE4: settled supply takes over aux, no reset
// RULE5: supply lost: fall back to bus regulator
// RULE6: controller negotiates then raises sink enable
// RULE7: enable low keeps disabled, protections off
// RULE8: enter sink on enable, secondary low, bus ok
// RULE9: sink: path on, protections armed, ovp optional
// RULE10: both enables low return to disabled
// RULE11: overvoltage or overtemperature enters fault, path off
// RULE12: fault exits on enable low or cleared
// RULE13: open-drain low only for ovp and ovt
// RULE14: fault pin held for minimum hold time
// RULE15: bus undervoltage keeps path off
// RULE16: reverse current blocks path, auto recovers
// RULE17: path temperature hysteresis on trip levels
// RULE18: overvoltage in sink switches off, flags fault
// RULE19: main overtemperature kills path and regulator
// RULE20: settle and hold are parameterised counters
module spc_sink_ctrl
    import spc_pkg::*;
#(
    parameter logic [19:0] SETTLE_CYCLES = 20'(`SPC_SETTLE_CYCLES),
    parameter logic [19:0] HOLD_CYCLES   = 20'(`SPC_HOLD_CYCLES)
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic sink_enable_in_i,
    input  wire logic secondary_enable_in_i,
    input  wire logic system_supply_ok_i,
    input  wire logic bus_uv_ok_i,
    input  wire logic ovp_grounded_i,
    input  wire logic bus_ovp_det_i,
    input  wire logic rcp_det_i,
    input  wire logic temp_above_rising_i,
    input  wire logic temp_below_falling_i,
    input  wire logic main_temp_trip_i,
    output logic      path_on_o,
    output logic      bus_reg_en_o,
    output logic      supply_select_switch_o,
    output logic      fault_n_out_o,
    output logic      fault_n_out_oe_o,
    output logic      protect_armed_o,
    output logic      ovp_armed_o,
    output logic      uvlo_active_o,
    output spc_pkg::spc_state_t state_o
);
    import spc_pkg::*;

    // ---------------------------------------------------------------
    // supply qualification
    // ---------------------------------------------------------------
    logic       supply_stable;
    logic       path_hot_reg;
    logic       fault_event;
    logic       fault_active;
    spc_state_t state_reg;
    spc_state_t state_next;
    logic       ovp_hit;

    spc_stable_timer #(
        .LIMIT    (SETTLE_CYCLES)
    ) u_settle (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .level_i  (system_supply_ok_i),
        .stable_o (supply_stable)
    ); // RULE20
    // entry also waits for a settled supply, so a dead-battery start
    // keeps the path off until the system rail has come up and held

    // ---------------------------------------------------------------
    // temperature hysteresis
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            path_hot_reg <= 1'b0;
        end else if (temp_above_rising_i) begin
            path_hot_reg <= 1'b1; // RULE17
        end else if (temp_below_falling_i) begin
            path_hot_reg <= 1'b0; // RULE17
        end
    end

    // ---------------------------------------------------------------
    // overvoltage qualification
    // ---------------------------------------------------------------
    // overvoltage only counts when the sense pin is not grounded
    assign ovp_hit = bus_ovp_det_i && !ovp_grounded_i; // RULE9

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    // conditions that force the sink-fault state
    function automatic logic spc_hazard(
        input logic ovp,
        input logic hot_latched,
        input logic hot_now
    );
        return ovp || hot_latched || hot_now;
    endfunction : spc_hazard

    function automatic logic spc_engaged(
        input spc_state_t st
    );
        return (st != SPC_DISABLED);
    endfunction : spc_engaged

    function automatic logic spc_path_ok(
        input spc_state_t st,
        input logic       bus_ok,
        input logic       reverse,
        input logic       main_trip,
        input logic       settled
    );
        return (st == SPC_SINK_ACTIVE) && bus_ok && !reverse && !main_trip && settled;
    endfunction : spc_path_ok

    // ---------------------------------------------------------------
    // state machine
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SPC_DISABLED: begin
                // RULE7 RULE8 RULE1 RULE15
                if (!secondary_enable_in_i && sink_enable_in_i && bus_uv_ok_i && supply_stable) begin
                    state_next = SPC_SINK_ACTIVE;
                end
            end
            SPC_SINK_ACTIVE: begin
                if (!secondary_enable_in_i && !sink_enable_in_i) begin
                    state_next = SPC_DISABLED; // RULE10
                end else if (spc_hazard(ovp_hit, path_hot_reg, temp_above_rising_i)) begin
                    state_next = SPC_SINK_FAULT; // RULE11 RULE18
                end
            end
            SPC_SINK_FAULT: begin
                if (!sink_enable_in_i) begin
                    state_next = SPC_DISABLED; // RULE12
                end else if (!spc_hazard(ovp_hit, path_hot_reg, temp_above_rising_i)) begin
                    state_next = SPC_SINK_ACTIVE; // RULE12
                end
            end
            default: begin
                state_next = SPC_DISABLED;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= SPC_DISABLED;
        end else begin
            state_reg <= state_next;
        end
    end

    // ---------------------------------------------------------------
    // sink path
    // ---------------------------------------------------------------
    // decided on the next state so the path drops on the same edge
    // that enters fault, not one cycle later
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            path_on_o <= 1'b0;
        end else begin
            // RULE9 RULE11 RULE15 RULE16 RULE19 RULE1
            path_on_o <= spc_path_ok(state_next, bus_uv_ok_i, rcp_det_i, main_temp_trip_i, supply_stable);
        end
    end

    // ---------------------------------------------------------------
    // temperature and reverse-current protection arming
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            protect_armed_o <= 1'b0;
        end else begin
            protect_armed_o <= spc_engaged(state_next); // RULE7 RULE9
        end
    end

    // ---------------------------------------------------------------
    // overvoltage protection arming
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ovp_armed_o <= 1'b0;
        end else begin
            ovp_armed_o <= spc_engaged(state_next) && !ovp_grounded_i; // RULE9
        end
    end

    // ---------------------------------------------------------------
    // undervoltage lockouts
    // ---------------------------------------------------------------
    // both lockouts stay armed in every state
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            uvlo_active_o <= 1'b1;
        end else begin
            uvlo_active_o <= 1'b1; // RULE7
        end
    end

    // ---------------------------------------------------------------
    // state report
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_o <= SPC_DISABLED;
        end else begin
            state_o <= state_next;
        end
    end

    // ---------------------------------------------------------------
    // aux supply select switch
    // ---------------------------------------------------------------
    // no reset is generated on the take-over; losing supply may still
    // brown out the aux rail, which is outside this logic
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            supply_select_switch_o <= 1'b0;
        end else begin
            supply_select_switch_o <= supply_stable; // RULE2 RULE4 RULE5
        end
    end

    // ---------------------------------------------------------------
    // bus regulator enable
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bus_reg_en_o <= 1'b0;
        end else begin
            bus_reg_en_o <= !supply_stable && bus_uv_ok_i && !main_temp_trip_i; // RULE3 RULE5 RULE19
        end
    end

    // ---------------------------------------------------------------
    // fault qualification and hold
    // ---------------------------------------------------------------
    // undervoltage and reverse current deliberately left out
    assign fault_event = spc_engaged(state_reg) && (ovp_hit || path_hot_reg); // RULE13

    spc_fault_hold #(
        .HOLD     (HOLD_CYCLES)
    ) u_hold (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .fault_i  (fault_event),
        .active_o (fault_active)
    ); // RULE14 RULE20

    // ---------------------------------------------------------------
    // fault pin drive value
    // ---------------------------------------------------------------
    // open drain: the value is low once out of reset (reset loads high), the pull-up does the rest
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fault_n_out_o <= 1'b1;
        end else begin
            fault_n_out_o <= 1'b0; // RULE13
        end
    end

    // ---------------------------------------------------------------
    // fault pin output enable
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fault_n_out_oe_o <= 1'b0;
        end else begin
            fault_n_out_oe_o <= fault_active; // RULE13 RULE14
        end
    end
endmodule : spc_sink_ctrl

// >>> logic/spc_stable_timer.sv
/*
 * qualifies a level: output rises one cycle after input has been held high for limit cycles.
 * assumes input is synchronous to clk_i.
 */
module spc_stable_timer #(
    parameter logic [19:0] LIMIT = 20'h00001
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic level_i,
    output logic      stable_o
);
    logic [19:0] count_reg;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_reg <= 20'h00000;
        end else if (!level_i) begin
            count_reg <= 20'h00000;
        end else if (count_reg != LIMIT) begin
            count_reg <= count_reg + 20'h00001;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stable_o <= 1'b0;
        end else begin
            stable_o <= level_i && (count_reg == LIMIT);
        end
    end
endmodule : spc_stable_timer

// >>> testbench/spc_pd_model.sv
/* controller model: raises enable after a negotiation delay.
   assumes the fault pin level is resolved by the bench */
module spc_pd_model #(
    parameter int DELAY = 3
) (
    input  wire logic clk_i,
    input  wire logic want_i,
    input  wire logic fault_pin_i,
    output logic      sink_enable_o,
    output logic      fault_seen_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic want_q = 1'b0;
    int   cnt    = 0;
    initial sink_enable_o = 1'b0;
    always @(posedge clk_i) begin
        want_q <= want_i;
        cnt    <= want_i ? cnt + 1 : 0;
    end
    // contract first, then enable
    always @(negedge clk_i) sink_enable_o <= want_q && cnt > DELAY;
    assign fault_seen_o = !fault_pin_i;
endmodule : spc_pd_model

// >>> testbench/spc_sink_ctrl_asserts.sv
/* checker for spc_sink_ctrl ports.
   assumes bind from the bench, hold count 8 */
module spc_sink_ctrl_asserts
    import spc_pkg::*;
#(
    parameter logic [19:0] SETTLE_CYCLES = 20'h00004,
    parameter logic [19:0] HOLD_CYCLES   = 20'h00008
) (
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic       sink_enable_in_i,
    input wire logic       secondary_enable_in_i,
    input wire logic       ovp_grounded_i,
    input wire logic       bus_ovp_det_i,
    input wire logic       rcp_det_i,
    input wire logic       main_temp_trip_i,
    input wire logic       path_on_o,
    input wire logic       bus_reg_en_o,
    input wire logic       supply_select_switch_o,
    input wire logic       fault_n_out_o,
    input wire logic       fault_n_out_oe_o,
    input wire logic       protect_armed_o,
    input wire logic       uvlo_active_o,
    input wire spc_state_t state_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // pin held low for the whole hold window
    sequence s_held;
        fault_n_out_oe_o[*8];
    endsequence
    a_path_in_sink: assert property (path_on_o |-> state_o == SPC_SINK_ACTIVE) else $error("path on outside sink");
    a_disabled_safe: assert property (state_o == SPC_DISABLED |-> !protect_armed_o) else $error("armed while off");
    a_uvlo_kept: assert property (uvlo_active_o) else $error("uvlo dropped");
    a_both_low_exit: assert property (!sink_enable_in_i && !secondary_enable_in_i |=> state_o == SPC_DISABLED)
        else $error("no return to disabled");
    a_rcp_blocks: assert property (state_o == SPC_SINK_ACTIVE && rcp_det_i |=> !path_on_o) else $error("rcp no block");
    a_ovp_fault: assert property (state_o == SPC_SINK_ACTIVE && sink_enable_in_i && !ovp_grounded_i && bus_ovp_det_i
        |=> state_o == SPC_SINK_FAULT && !path_on_o) else $error("ovp not handled");
    a_hold_min: assert property ($rose(fault_n_out_oe_o) |-> s_held) else $error("fault hold short");
    a_open_drain: assert property (fault_n_out_oe_o |-> !fault_n_out_o) else $error("pin driven high");
    a_select_excl: assert property (supply_select_switch_o |-> !bus_reg_en_o) else $error("both aux feeds on");
    a_main_trip: assert property (main_temp_trip_i |=> !bus_reg_en_o && !path_on_o) else $error("main trip ignored");
endmodule : spc_sink_ctrl_asserts

// >>> testbench/spc_sink_ctrl_tb.sv
/* self-checking bench for spc_sink_ctrl.
   assumes small counts: settle 4, hold 8 */
module spc_sink_ctrl_tb;
    import spc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, nrst_i = 0, want = 0, sec = 0, sup = 0, bus = 1, gnd = 0, ovp = 0, rcp = 0, hot = 0, cool = 1, mt = 0;
    logic en, path, reg_en, sw, fn, oe, arm, oarm, uv, fault_n_out;
    spc_state_t st;
    int fails = 0, tests_run = 0, cycles = 0;
    wire pin = oe ? fn : 1'b1;
    always #10 clk_i = ~clk_i;
    spc_sink_ctrl #(.SETTLE_CYCLES(20'h00004), .HOLD_CYCLES(20'h00008)) i_spc_sink_ctrl (.clk_i(clk_i),
        .nrst_i(nrst_i), .sink_enable_in_i(en), .secondary_enable_in_i(sec), .system_supply_ok_i(sup),
        .bus_uv_ok_i(bus), .ovp_grounded_i(gnd), .bus_ovp_det_i(ovp), .rcp_det_i(rcp), .temp_above_rising_i(hot),
        .temp_below_falling_i(cool), .main_temp_trip_i(mt), .path_on_o(path), .bus_reg_en_o(reg_en),
        .supply_select_switch_o(sw), .fault_n_out_o(fn), .fault_n_out_oe_o(oe), .protect_armed_o(arm),
        .ovp_armed_o(oarm), .uvlo_active_o(uv), .state_o(st));
    spc_pd_model #(.DELAY(3)) i_spc_pd_model (.clk_i(clk_i), .want_i(want), .fault_pin_i(pin),
        .sink_enable_o(en), .fault_seen_o(fault_n_out));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc
    task automatic chk(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask : chk
    task automatic t_supply;
        want = 1;
        cyc(8);
        chk("reg_en", 1, reg_en);
        chk("path", 0, path);
        sup = 1;
        cyc(2);
        chk("path", 0, path);
        cyc(12);
        chk("path", 1, path);
        chk("switch", 1, sw);
        chk("reg_en", 0, reg_en);
        sup = 0;
        cyc(4);
        chk("reg_en", 1, reg_en);
        sup = 1;
        cyc(14);
        $display("supply test done");
    endtask : t_supply
    task automatic t_fault(input bit ot);
        if (ot) {hot, cool} = 2'b10;
        else ovp = 1;
        cyc(3);
        chk("fault", 1, fault_n_out);
        chk("path", 0, path);
        {hot, cool, ovp} = 3'b010;
        cyc(2);
        chk("fault", 1, fault_n_out);
        cyc(12);
        chk("fault", 0, fault_n_out);
        chk("path", 1, path);
        $display("fault test done");
    endtask : t_fault
    task automatic t_rcp;
        rcp = 1;
        cyc(3);
        chk("path", 0, path);
        chk("fault", 0, fault_n_out);
        rcp = 0;
        cyc(3);
        chk("path", 1, path);
        mt = 1;
        sup = 0;
        cyc(2);
        chk("reg_en", 0, reg_en);
        chk("path", 0, path);
        mt = 0;
        cyc(2);
        chk("reg_en", 1, reg_en);
        sup = 1;
        cyc(7);
        chk("path", 1, path);
        $display("rcp test done");
    endtask : t_rcp
    task automatic t_exit;
        want = 0;
        cyc(3);
        chk("off", 1, st === SPC_DISABLED);
        chk("armed", 0, arm);
        sec = 1;
        want = 1;
        cyc(8);
        chk("off", 1, st === SPC_DISABLED);
        sec = 0;
        cyc(3);
        chk("path", 1, path);
        chk("ovp_arm", 1, oarm);
        chk("uvlo", 1, uv);
        {gnd, ovp} = 2'b11;
        cyc(3);
        chk("ovp_arm", 0, oarm);
        chk("path", 1, path);
        chk("fault", 0, fault_n_out);
        {gnd, ovp} = 2'b00;
        bus = 0;
        cyc(3);
        chk("path", 0, path);
        $display("exit test done");
    endtask : t_exit
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        cyc(6);
        nrst_i = 1;
        t_supply();
        t_fault(0);
        t_fault(1);
        t_rcp();
        t_exit();
        final_report();
    end
endmodule : spc_sink_ctrl_tb
bind spc_sink_ctrl spc_sink_ctrl_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) i_chk (.*);
